// ---- ulms_top.sv ----
`timescale 1ns/1ns
// Notes on behaviour
// - parity bit shows top received character
// - overrun flagged when char completes, fifo full
// - overrun char dropped, fifo left untouched
// - data ready while any char held
// - modem status read-only, writes hit feature control
// - reading modem status clears change bits
// - bit 7 carrier detect, loopback user output 2
// - bit 6 ring, loopback user output 1
// - bit 5 set ready, loopback terminal ready
// - bit 4 clear to send, loopback request
// - cts, dsr, cd change bits latch on any edge
// - ring change only on trailing edge
// - modem interrupt while any change bit set
// - bit 7 while flagged char in fifo, fifo mode only
module ulms_top #(
   parameter int DEPTH = ulms_pkg::FIFO_DEPTH,
   parameter int AW    = $clog2(DEPTH)
) (
   input  wire logic        SYS_CLK,
   input  wire logic        RST,
   input  wire logic [2:0]  REG_ADDR,
   input  wire logic [7:0]  REG_WDATA,
   input  wire logic        REG_WR,
   input  wire logic        REG_RD,
   output logic      [7:0]  REG_RDATA,
   input  wire logic        RX_CHAR_DONE,
   input  wire logic [7:0]  RX_CHAR_DATA,
   input  wire logic        RX_PARITY_ERR,
   input  wire logic        RX_FRAME_ERR,
   input  wire logic        RX_BREAK,
   input  wire logic        CTS_N,
   input  wire logic        DSR_N,
   input  wire logic        RI_N,
   input  wire logic        CD_N,
   output logic             DTR_N,
   output logic             RTS_N,
   output logic             USER_OUT1_N,
   output logic             USER_OUT2_N,
   output logic [7:0]       EXTRA_FEATURE_CTRL,
   output logic             MODEM_IRQ,
   output logic             IRQ
);
   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   typedef struct packed {
      logic [AW-1:0] wp;        // fifo write pointer
      logic [AW-1:0] rp;        // fifo read pointer
      logic [AW:0]   cnt;       // characters held
      logic [AW:0]   err_cnt;   // flagged characters held
      logic          overrun;   // line overrun flag
      logic          fifo_en;   // fifo mode
      logic [4:0]    mc;        // modem control
      logic [7:0]    efc;       // extra feature control
      logic [3:0]    delta;     // modem change bits
      logic [3:0]    prev;      // last modem levels
      logic [3:0]    int_stat;  // sticky events
      logic [3:0]    int_mask;  // event mask
      logic [7:0]    rdata;     // read data
      logic          msi;       // modem interrupt
      logic          irq;       // summary interrupt
      logic [3:0]    mc_out_n;  // pin drives
   } ulms_st_t;

   ulms_st_t st_r;
   ulms_st_t st_nxt;

   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   // one bit of a sticky flag: set beats clear
   function automatic logic sticky(input logic cur, input logic set,
                                   input logic clr);
      sticky = set | (cur & ~clr);
   endfunction : sticky

   // wrap a fifo pointer
   function automatic logic [AW-1:0] ptr_inc(input logic [AW-1:0] p);
      if (p == AW'(DEPTH - 1)) begin
         ptr_inc = '0;
      end else begin
         ptr_inc = p + AW'(1);
      end
   endfunction : ptr_inc

   // ------------------------------------------------------------
   // pin synchroniser
   // ------------------------------------------------------------
   logic [3:0] pins_n_s;                    // synced low-active inputs

   ulms_sync #(
      .W       (ulms_pkg::MS_IN_W),
      .RST_VAL (ulms_pkg::PIN_IDLE)
   ) u_sync (
      .clk (SYS_CLK),
      .rst (RST),
      .d   ({CD_N, RI_N, DSR_N, CTS_N}),
      .q   (pins_n_s)
   );

   // ------------------------------------------------------------
   // receive fifo storage
   // ------------------------------------------------------------
   logic                       push;       // write a char
   logic                       pop;        // host takes a char
   logic [ulms_pkg::ENTRY_W-1:0] top;      // entry at fifo head
   logic [AW-1:0]              rp_next;    // head after this cycle

   ulms_rx_mem #(
      .DEPTH (DEPTH),
      .W     (ulms_pkg::ENTRY_W),
      .AW    (AW)
   ) u_mem (
      .clk   (SYS_CLK),
      .rst   (RST),
      .we    (push),
      .waddr (st_r.wp),
      .wdata ({RX_BREAK, RX_FRAME_ERR, RX_PARITY_ERR, RX_CHAR_DATA}),
      .raddr (rp_next),
      .rdata (top)
   );

   // ------------------------------------------------------------
   // decode and datapath terms
   // ------------------------------------------------------------
   logic       rd_rx;      // read of receive data
   logic       rd_ls;      // read of line status
   logic       rd_ms;      // read of modem status
   logic       rd_is;      // read of interrupt status
   logic       full;       // no room for a char
   logic       top_err;    // head char carries a flag
   logic       new_err;    // incoming char carries a flag
   logic [3:0] lvl;        // modem levels, high active
   logic [7:0] ls_val;     // line status word
   logic [7:0] ms_val;     // modem status word

   always_comb begin
      rd_rx   = REG_RD && (REG_ADDR == ulms_pkg::OFF_RX_DATA);
      rd_ls   = REG_RD && (REG_ADDR == ulms_pkg::OFF_LINE_STAT);
      rd_ms   = REG_RD && (REG_ADDR == ulms_pkg::OFF_MODEM_STAT);
      rd_is   = REG_RD && (REG_ADDR == ulms_pkg::OFF_INT_STAT);
      // holding register mode keeps one char
      if (st_r.fifo_en) begin
         full = (st_r.cnt == (AW+1)'(DEPTH));
      end else begin
         full = (st_r.cnt != '0);
      end
      // overrun char is dropped, fifo untouched
      push    = RX_CHAR_DONE && !full;
      pop     = rd_rx && (st_r.cnt != '0);
      rp_next = pop ? ptr_inc(st_r.rp) : st_r.rp;
      top_err = top[ulms_pkg::FL_PE] | top[ulms_pkg::FL_FE]
                | top[ulms_pkg::FL_BK];
      new_err = RX_PARITY_ERR | RX_FRAME_ERR | RX_BREAK;
      // modem levels: pins inverted, or own outputs in loopback
      if (st_r.mc[ulms_pkg::MC_LOOP]) begin
         lvl[ulms_pkg::MI_CD]  = st_r.mc[ulms_pkg::MC_OUT2];
         lvl[ulms_pkg::MI_RI]  = st_r.mc[ulms_pkg::MC_OUT1];
         lvl[ulms_pkg::MI_DSR] = st_r.mc[ulms_pkg::MC_DTR];
         lvl[ulms_pkg::MI_CTS] = st_r.mc[ulms_pkg::MC_RTS];
      end else begin
         lvl = ~pins_n_s;
      end
      // line status word
      ls_val                       = '0;
      ls_val[ulms_pkg::LS_READY]   = (st_r.cnt != '0);
      ls_val[ulms_pkg::LS_OVERRUN] = st_r.overrun;
      ls_val[ulms_pkg::LS_PARITY]  = (st_r.cnt != '0)
                                     && top[ulms_pkg::FL_PE];
      ls_val[ulms_pkg::LS_FIFOERR] = st_r.fifo_en
                                     && (st_r.err_cnt != '0);
      ms_val = {st_r.prev, st_r.delta};
   end

   // ------------------------------------------------------------
   // next state
   // ------------------------------------------------------------
   logic [3:0] chg;        // modem change events this cycle
   logic [3:0] ev;         // interrupt events this cycle

   always_comb begin
      st_nxt = st_r;
      chg    = '0;
      ev     = '0;

      // fifo pointers and counts
      if (push) begin
         st_nxt.wp = ptr_inc(st_r.wp);
      end
      st_nxt.rp = rp_next;
      if (push && !pop) begin
         st_nxt.cnt = st_r.cnt + (AW+1)'(1);
      end else if (pop && !push) begin
         st_nxt.cnt = st_r.cnt - (AW+1)'(1);
      end
      // count of errored chars still held
      if ((push && new_err) && !(pop && top_err)) begin
         st_nxt.err_cnt = st_r.err_cnt + (AW+1)'(1);
      end else if ((pop && top_err) && !(push && new_err)) begin
         st_nxt.err_cnt = st_r.err_cnt - (AW+1)'(1);
      end

      // overrun: char done while full, cleared by line status read
      st_nxt.overrun = sticky(st_r.overrun, RX_CHAR_DONE && full, rd_ls);

      // modem change detection
      chg[ulms_pkg::MI_CTS] = lvl[ulms_pkg::MI_CTS] ^ st_r.prev[ulms_pkg::MI_CTS];
      chg[ulms_pkg::MI_DSR] = lvl[ulms_pkg::MI_DSR] ^ st_r.prev[ulms_pkg::MI_DSR];
      chg[ulms_pkg::MI_CD]  = lvl[ulms_pkg::MI_CD] ^ st_r.prev[ulms_pkg::MI_CD];
      // ring pin low to high is level high to low
      chg[ulms_pkg::MI_RI]  = st_r.prev[ulms_pkg::MI_RI]
                              & ~lvl[ulms_pkg::MI_RI];
      st_nxt.prev = lvl;
      for (int i = 0; i < ulms_pkg::MS_IN_W; i++) begin
         st_nxt.delta[i] = sticky(st_r.delta[i], chg[i], rd_ms);
      end
      // interrupt follows change bits, drops once read clean
      st_nxt.msi = |st_nxt.delta;

      // interrupt events
      ev[ulms_pkg::INT_RX]    = push;
      ev[ulms_pkg::INT_OVR]   = RX_CHAR_DONE && full;
      ev[ulms_pkg::INT_LERR]  = push && new_err;
      ev[ulms_pkg::INT_MODEM] = |chg;
      for (int i = 0; i < ulms_pkg::INT_W; i++) begin
         st_nxt.int_stat[i] = sticky(st_r.int_stat[i], ev[i], rd_is);
      end

      // register writes
      if (REG_WR) begin
         unique case (REG_ADDR)
            ulms_pkg::OFF_INT_MASK: begin
               st_nxt.int_mask = REG_WDATA[3:0];
            end
            ulms_pkg::OFF_FIFO_CTRL: begin
               // mode change flushes held chars
               st_nxt.fifo_en = REG_WDATA[0];
               st_nxt.wp      = '0;
               st_nxt.rp      = '0;
               st_nxt.cnt     = '0;
               st_nxt.err_cnt = '0;
            end
            ulms_pkg::OFF_MODEM_CTRL: begin
               st_nxt.mc = REG_WDATA[4:0];
            end
            ulms_pkg::OFF_MODEM_STAT: begin
               // status is read-only, write lands here
               st_nxt.efc = REG_WDATA;
            end
            default: begin
               // other offsets ignore writes
            end
         endcase
      end

      // read data, next cycle only
      st_nxt.rdata = '0;
      if (REG_RD) begin
         unique case (REG_ADDR)
            ulms_pkg::OFF_RX_DATA:    st_nxt.rdata = (st_r.cnt != '0) ? top[7:0] : '0;
            ulms_pkg::OFF_INT_MASK:   st_nxt.rdata = {4'h0, st_r.int_mask};
            ulms_pkg::OFF_FIFO_CTRL:  st_nxt.rdata = {7'h00, st_r.fifo_en};
            ulms_pkg::OFF_INT_STAT:   st_nxt.rdata = {4'h0, st_r.int_stat};
            ulms_pkg::OFF_MODEM_CTRL: st_nxt.rdata = {3'h0, st_r.mc};
            ulms_pkg::OFF_LINE_STAT:  st_nxt.rdata = ls_val;
            ulms_pkg::OFF_MODEM_STAT: st_nxt.rdata = ms_val;
            default:                  st_nxt.rdata = '0;
         endcase
      end

      // interrupt summary from next status
      st_nxt.irq = |(st_nxt.int_stat & st_nxt.int_mask);

      // modem outputs idle high in loopback
      if (st_nxt.mc[ulms_pkg::MC_LOOP]) begin
         st_nxt.mc_out_n = 4'hF;
      end else begin
         st_nxt.mc_out_n = ~st_nxt.mc[3:0];
      end
   end

   // ------------------------------------------------------------
   // registers
   // ------------------------------------------------------------
   always_ff @(posedge SYS_CLK or posedge RST) begin
      if (RST) begin
         st_r          <= '0;
         st_r.mc       <= ulms_pkg::MC_RST;
         st_r.efc      <= ulms_pkg::EFC_RST;
         st_r.int_mask <= ulms_pkg::MASK_RST;
         st_r.mc_out_n <= 4'hF;
      end else begin
         st_r <= st_nxt;
      end
   end

   // ------------------------------------------------------------
   // outputs
   // ------------------------------------------------------------
   assign REG_RDATA          = st_r.rdata;
   assign DTR_N              = st_r.mc_out_n[ulms_pkg::MC_DTR];
   assign RTS_N              = st_r.mc_out_n[ulms_pkg::MC_RTS];
   assign USER_OUT1_N        = st_r.mc_out_n[ulms_pkg::MC_OUT1];
   assign USER_OUT2_N        = st_r.mc_out_n[ulms_pkg::MC_OUT2];
   assign EXTRA_FEATURE_CTRL = st_r.efc;
   assign MODEM_IRQ          = st_r.msi;
   assign IRQ                = st_r.irq;
endmodule : ulms_top

// ---- ulms_pkg.sv ----
package ulms_pkg;
   // ------------------------------------------------------------
   // widths and sizes
   // ------------------------------------------------------------
   localparam int          ADDR_W     = 3;       // register index width
   localparam int          DATA_W     = 8;       // register data width
   localparam int          FIFO_DEPTH = 128;     // receive fifo depth
   localparam int          ENTRY_W    = 11;      // data plus three flags
   localparam int          MC_W       = 5;       // modem control width
   localparam int          MS_IN_W    = 4;       // modem inputs
   localparam int          INT_W      = 4;       // interrupt sources

   // ------------------------------------------------------------
   // register indices
   // ------------------------------------------------------------
   localparam logic [2:0]  OFF_RX_DATA    = 3'h0;  // read pops fifo
   localparam logic [2:0]  OFF_INT_MASK   = 3'h1;  // rw mask
   localparam logic [2:0]  OFF_FIFO_CTRL  = 3'h2;  // bit0 fifo mode
   localparam logic [2:0]  OFF_INT_STAT   = 3'h3;  // sticky, read clears
   localparam logic [2:0]  OFF_MODEM_CTRL = 3'h4;  // rw
   localparam logic [2:0]  OFF_LINE_STAT  = 3'h5;  // ro
   localparam logic [2:0]  OFF_MODEM_STAT = 3'h6;  // ro, write = efc

   // ------------------------------------------------------------
   // field positions
   // ------------------------------------------------------------
   localparam int          LS_READY   = 0;       // data ready
   localparam int          LS_OVERRUN = 1;       // overrun
   localparam int          LS_PARITY  = 2;       // parity of top char
   localparam int          LS_FIFOERR = 7;       // error in fifo
   localparam int          MC_DTR     = 0;       // terminal ready
   localparam int          MC_RTS     = 1;       // request to send
   localparam int          MC_OUT1    = 2;       // user output 1
   localparam int          MC_OUT2    = 3;       // user output 2
   localparam int          MC_LOOP    = 4;       // loopback
   localparam int          MI_CTS     = 0;       // modem vector order
   localparam int          MI_DSR     = 1;
   localparam int          MI_RI      = 2;
   localparam int          MI_CD      = 3;
   localparam int          FL_PE      = 8;       // entry parity flag
   localparam int          FL_FE      = 9;       // entry framing flag
   localparam int          FL_BK      = 10;      // entry break flag
   localparam int          INT_RX     = 0;       // char received
   localparam int          INT_OVR    = 1;       // overrun
   localparam int          INT_LERR   = 2;       // errored char
   localparam int          INT_MODEM  = 3;       // modem change

   // ------------------------------------------------------------
   // reset values
   // ------------------------------------------------------------
   localparam logic [7:0]  EFC_RST    = 8'h00;
   localparam logic [4:0]  MC_RST     = 5'h00;
   localparam logic [3:0]  MASK_RST   = 4'h0;
   localparam logic [3:0]  PIN_IDLE   = 4'hF;    // low-active pins idle
endpackage : ulms_pkg

// ---- ulms_sync.sv ----
`timescale 1ns/1ns
module ulms_sync #(
   parameter int         W       = 4,
   parameter logic [W-1:0] RST_VAL = '0
) (
   input  wire logic         clk,
   input  wire logic         rst,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);
   // ------------------------------------------------------------
   // two-stage synchroniser
   // ------------------------------------------------------------
   typedef struct packed {
      logic [W-1:0] s1;   // first stage, read only by s2
      logic [W-1:0] s2;   // second stage
   } ulms_sync_t;

   ulms_sync_t st_r;
   ulms_sync_t st_nxt;

   // next state
   always_comb begin
      st_nxt    = st_r;
      st_nxt.s1 = d;
      st_nxt.s2 = st_r.s1;
   end

   // registers
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         st_r <= {RST_VAL, RST_VAL};
      end else begin
         st_r <= st_nxt;
      end
   end

   assign q = st_r.s2;
endmodule : ulms_sync

// ---- ulms_rx_mem.sv ----
`timescale 1ns/1ns
module ulms_rx_mem #(
   parameter int DEPTH = 128,
   parameter int W     = 11,
   parameter int AW    = $clog2(DEPTH)
) (
   input  wire logic          clk,
   input  wire logic          rst,
   input  wire logic          we,
   input  wire logic [AW-1:0] waddr,
   input  wire logic [W-1:0]  wdata,
   input  wire logic [AW-1:0] raddr,
   output logic      [W-1:0]  rdata
);
   // ------------------------------------------------------------
   // storage with registered read port
   // ------------------------------------------------------------
   typedef struct packed {
      logic [DEPTH-1:0][W-1:0] arr;  // entries
      logic [W-1:0]            rd;   // read register
   } ulms_mem_t;

   ulms_mem_t st_r;
   ulms_mem_t st_nxt;

   // write and read, with bypass of a same-cycle write
   always_comb begin
      st_nxt = st_r;
      if (we) begin
         st_nxt.arr[waddr] = wdata;
      end
      if (we && (waddr == raddr)) begin
         st_nxt.rd = wdata;            // bypass
      end else begin
         st_nxt.rd = st_r.arr[raddr];
      end
   end

   // registers
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign rdata = st_r.rd;
endmodule : ulms_rx_mem

// ---- ulms_checker.sv ----
`timescale 1ns/1ns
module ulms_checker (
   input wire logic       SYS_CLK,
   input wire logic       RST,
   input wire logic [2:0] REG_ADDR,
   input wire logic [7:0] REG_WDATA,
   input wire logic       REG_WR,
   input wire logic       REG_RD,
   input wire logic [7:0] REG_RDATA,
   input wire logic       CTS_N,
   input wire logic       DSR_N,
   input wire logic       RI_N,
   input wire logic       CD_N,
   input wire logic       DTR_N,
   input wire logic       RTS_N,
   input wire logic       USER_OUT1_N,
   input wire logic       USER_OUT2_N,
   input wire logic [7:0] EXTRA_FEATURE_CTRL,
   input wire logic       MODEM_IRQ
);
   default clocking cb @(posedge SYS_CLK); endclocking
   default disable iff (RST);
   // ----------------------------------------
   // helper state
   // ----------------------------------------
   logic [3:0] pins;     // pins in status bit order
   logic [3:0] pins_r;   // pins one cycle back
   logic [2:0] quiet_r;  // cycles since last pin or control change
   logic [4:0] mc_r;     // shadow of modem control
   logic       mc_wr;    // modem control write this cycle
   assign pins  = {CD_N, RI_N, DSR_N, CTS_N};
   assign mc_wr = REG_WR && REG_ADDR == 3'h4;
   // quiet counter lets the synchroniser settle before checking
   always_ff @(posedge SYS_CLK or posedge RST) begin
      if (RST) begin
         pins_r  <= 4'hF;
         quiet_r <= 3'h0;
         mc_r    <= 5'h00;
      end else begin
         pins_r <= pins;
         if (pins != pins_r || mc_wr) begin
            quiet_r <= 3'h0;
         end else if (quiet_r != 3'h7) begin
            quiet_r <= quiet_r + 3'h1;
         end
         if (mc_wr) begin
            mc_r <= REG_WDATA[4:0];
         end
      end
   end
   // ----------------------------------------
   // assertions
   // ----------------------------------------
   chk_efc_write: assert property (
      REG_WR && REG_ADDR == 3'h6 |=> EXTRA_FEATURE_CTRL == $past(REG_WDATA))
      else $error("feature control not written");
   chk_efc_hold: assert property (
      !(REG_WR && REG_ADDR == 3'h6) |=> $stable(EXTRA_FEATURE_CTRL))
      else $error("feature control changed without write");
   chk_irq_matches_bits: assert property (
      REG_RD && REG_ADDR == 3'h6 |=> (|REG_RDATA[3:0]) == $past(MODEM_IRQ))
      else $error("modem irq differs from change bits");
   chk_irq_drops: assert property (
      REG_RD && REG_ADDR == 3'h6 && quiet_r >= 3'h4 |=> !MODEM_IRQ)
      else $error("modem irq stays after clearing read");
   chk_read_clears: assert property (
      (REG_RD && REG_ADDR == 3'h6 && quiet_r >= 3'h4) ##[1:4]
      (REG_RD && REG_ADDR == 3'h6 && quiet_r >= 3'h4) |=> REG_RDATA[3:0] == 4'h0)
      else $error("change bits survive a read");
   chk_live_pins: assert property (
      REG_RD && REG_ADDR == 3'h6 && !mc_r[4] && quiet_r >= 3'h4
      |=> REG_RDATA[7:4] == ~$past(pins))
      else $error("status does not follow pins");
   chk_loop_status: assert property (
      REG_RD && REG_ADDR == 3'h6 && mc_r[4]
      |=> REG_RDATA[7:4] == {mc_r[3], mc_r[2], mc_r[0], mc_r[1]})
      else $error("loopback status wrong");
   chk_loop_outs: assert property (
      mc_wr && REG_WDATA[4] |=> {DTR_N, RTS_N, USER_OUT1_N, USER_OUT2_N} == 4'hF)
      else $error("modem outputs active in loopback");
endmodule : ulms_checker

bind ulms_top ulms_checker u_chk (.SYS_CLK(SYS_CLK), .RST(RST), .REG_ADDR(REG_ADDR),
   .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA),
   .CTS_N(CTS_N), .DSR_N(DSR_N), .RI_N(RI_N), .CD_N(CD_N), .DTR_N(DTR_N),
   .RTS_N(RTS_N), .USER_OUT1_N(USER_OUT1_N), .USER_OUT2_N(USER_OUT2_N),
   .EXTRA_FEATURE_CTRL(EXTRA_FEATURE_CTRL), .MODEM_IRQ(MODEM_IRQ));

// ---- ulms_modem_model.sv ----
`timescale 1ns/1ns
module ulms_modem_model (
   input wire logic clk,
   input wire logic rst,
   input wire logic dtr_n,
   input wire logic rts_n,
   input wire logic ring_cmd,
   input wire logic carrier_cmd,
   input wire logic slow,
   output logic     cts_n,
   output logic     dsr_n,
   output logic     ri_n,
   output logic     cd_n
);
   // ----------------------------------------
   // handshake replies, prompt or slow
   // ----------------------------------------
   logic [7:0] dsr_sh_r;  // ready reply pipeline
   logic [7:0] cts_sh_r;  // clear reply pipeline
   // set ready follows terminal ready, clear follows request
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         dsr_sh_r <= 8'hFF;
         cts_sh_r <= 8'hFF;
      end else begin
         dsr_sh_r <= {dsr_sh_r[6:0], dtr_n};
         cts_sh_r <= {cts_sh_r[6:0], rts_n};
      end
   end
   assign dsr_n = slow ? dsr_sh_r[7] : dsr_sh_r[0];
   assign cts_n = slow ? cts_sh_r[7] : cts_sh_r[0];
   assign ri_n  = ~ring_cmd;     // ring pulled low on command
   assign cd_n  = ~carrier_cmd;  // carrier pulled low on command
endmodule : ulms_modem_model

// ---- uart_line_and_modem_status_tb_top.sv ----
`timescale 1ns/1ns
module uart_line_and_modem_status_tb_top;
   // ----------------------------------------
   // signals
   // ----------------------------------------
   localparam int DEPTH = 4;
   logic       sys_clk = 1'h0;
   logic       rst     = 1'h1;
   logic [2:0] reg_addr = 3'h0;
   logic [7:0] reg_wdata = 8'h00;
   logic       reg_wr = 1'h0;
   logic       reg_rd = 1'h0;
   logic [7:0] reg_rdata;
   logic       rx_done = 1'h0;
   logic [7:0] rx_data = 8'h00;
   logic       rx_pe = 1'h0;
   logic       rx_fe = 1'h0;
   logic       rx_bk = 1'h0;
   logic       cts_n, dsr_n, ri_n, cd_n, dtr_n, rts_n, out1_n, out2_n;
   logic       ring_cmd = 1'h0;
   logic       carrier_cmd = 1'h0;
   logic       slow = 1'h0;
   logic [7:0] efc;
   logic       modem_irq, irq;
   int         error_cnt = 0;
   int         checked = 0;
   int         cyc = 0;
   logic [7:0] loop_exp [4] = '{8'h20, 8'h10, 8'h40, 8'h80};

   always #4 sys_clk = ~sys_clk;

   ulms_top #(.DEPTH(DEPTH)) uut (.SYS_CLK(sys_clk), .RST(rst), .REG_ADDR(reg_addr),
      .REG_WDATA(reg_wdata), .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_RDATA(reg_rdata),
      .RX_CHAR_DONE(rx_done), .RX_CHAR_DATA(rx_data), .RX_PARITY_ERR(rx_pe),
      .RX_FRAME_ERR(rx_fe), .RX_BREAK(rx_bk), .CTS_N(cts_n), .DSR_N(dsr_n), .RI_N(ri_n),
      .CD_N(cd_n), .DTR_N(dtr_n), .RTS_N(rts_n), .USER_OUT1_N(out1_n),
      .USER_OUT2_N(out2_n), .EXTRA_FEATURE_CTRL(efc), .MODEM_IRQ(modem_irq), .IRQ(irq));

   ulms_modem_model u_modem (.clk(sys_clk), .rst(rst), .dtr_n(dtr_n), .rts_n(rts_n),
      .ring_cmd(ring_cmd), .carrier_cmd(carrier_cmd), .slow(slow), .cts_n(cts_n),
      .dsr_n(dsr_n), .ri_n(ri_n), .cd_n(cd_n));

   // ----------------------------------------
   // tasks
   // ----------------------------------------
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      checked++;
      if (got !== exp) begin
         error_cnt++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      reg_wr    <= 1'h1;
      reg_addr  <= a;
      reg_wdata <= d;
      @(posedge sys_clk);
      reg_wr <= 1'h0;
   endtask : wr

   // read, then compare the masked data in its one valid cycle
   task automatic rd(input logic [2:0] a, input logic [7:0] e, input logic [7:0] m);
      @(posedge sys_clk);
      reg_rd   <= 1'h1;
      reg_addr <= a;
      @(posedge sys_clk);
      reg_rd <= 1'h0;
      #1;
      chk(reg_rdata & m, e & m);
   endtask : rd

   // back-to-back characters, flags only on the first
   task automatic rx_burst(input logic [7:0] first, input int n, input logic [2:0] fl);
      for (int i = 0; i < n; i++) begin
         @(posedge sys_clk);
         rx_done <= 1'h1;
         rx_data <= first + 8'(i);
         {rx_bk, rx_fe, rx_pe} <= (i == 0) ? fl : 3'h0;
      end
      @(posedge sys_clk);
      rx_done <= 1'h0;
   endtask : rx_burst

   task automatic settle(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask : settle

   task automatic finish_test();
      if (error_cnt == 0 && checked > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : finish_test

   // hang guard
   always @(posedge sys_clk) begin
      cyc++;
      if (cyc == 4000) begin
         error_cnt++;
         finish_test();
      end
   end

   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial begin
      repeat (16) @(posedge sys_clk);
      rst <= 1'h0;
      rd(3'h5, 8'h00, 8'hFF);
      wr(3'h6, 8'hA5);
      settle(1);
      chk(efc, 8'hA5);
      rd(3'h6, 8'h00, 8'hFF);
      // handshake: terminal ready and request answered by the modem
      wr(3'h4, 8'h0F);
      settle(8);
      chk({4'h0, out2_n, out1_n, rts_n, dtr_n}, 8'h00);
      chk({7'h00, modem_irq}, 8'h01);
      rd(3'h6, 8'h33, 8'hFF);
      rd(3'h6, 8'h30, 8'hFF);
      chk({7'h00, modem_irq}, 8'h00);
      ring_cmd <= 1'h1;
      settle(8);
      rd(3'h6, 8'h70, 8'hFF);
      ring_cmd <= 1'h0;
      settle(8);
      rd(3'h6, 8'h34, 8'hFF);
      carrier_cmd <= 1'h1;
      settle(8);
      rd(3'h6, 8'hB8, 8'hFF);
      carrier_cmd <= 1'h0;
      settle(8);
      rd(3'h6, 8'h38, 8'hFF);
      // slow modem drops its replies late
      slow <= 1'h1;
      wr(3'h4, 8'h00);
      rd(3'h6, 8'h30, 8'hFF);
      settle(16);
      rd(3'h6, 8'h03, 8'hFF);
      // loopback: status follows modem control
      wr(3'h4, 8'h1F);
      rd(3'h6, 8'hFB, 8'hFF);
      for (int i = 0; i < 4; i++) begin
         wr(3'h4, 8'h10 | (8'h01 << i));
         rd(3'h6, loop_exp[i], 8'hF0);
      end
      wr(3'h4, 8'h00);
      settle(4);
      rd(3'h6, 8'h08, 8'hFF);
      // fifo mode: parity of head, overrun, data kept
      wr(3'h2, 8'h01);
      rx_burst(8'h41, 1, 3'h1);
      rd(3'h5, 8'h85, 8'hFF);
      rd(3'h0, 8'h41, 8'hFF);
      rd(3'h5, 8'h00, 8'hFF);
      rx_burst(8'h10, DEPTH + 1, 3'h2);
      rd(3'h5, 8'h83, 8'hFF);
      rd(3'h5, 8'h81, 8'hFF);
      for (int i = 0; i < DEPTH; i++) begin
         rd(3'h0, 8'h10 + 8'(i), 8'hFF);
      end
      rd(3'h5, 8'h00, 8'hFF);
      rd(3'h0, 8'h00, 8'hFF);
      // holding mode: second character overruns
      wr(3'h2, 8'h00);
      rx_burst(8'h55, 2, 3'h0);
      rd(3'h5, 8'h03, 8'hFF);
      rd(3'h0, 8'h55, 8'hFF);
      // interrupt: raise, mask, clear by read
      rd(3'h3, 8'h0F, 8'hFF);
      wr(3'h1, 8'h01);
      rx_burst(8'h77, 1, 3'h0);
      settle(2);
      chk({7'h00, irq}, 8'h01);
      wr(3'h1, 8'h00);
      settle(1);
      chk({7'h00, irq}, 8'h00);
      wr(3'h1, 8'h01);
      settle(1);
      chk({7'h00, irq}, 8'h01);
      rd(3'h3, 8'h01, 8'hFF);
      settle(1);
      chk({7'h00, irq}, 8'h00);
      // unmapped index and mid-run reset
      wr(3'h7, 8'hFF);
      rd(3'h7, 8'h00, 8'hFF);
      @(posedge sys_clk);
      rst <= 1'h1;
      settle(2);
      chk(efc, 8'h00);
      @(posedge sys_clk);
      rst <= 1'h0;
      rd(3'h5, 8'h00, 8'hFF);
      finish_test();
   end
endmodule : uart_line_and_modem_status_tb_top
